// ### core/tatc_timer.sv
// timer control register, prescaler, counter and write-transfer logic
//
// The register offsets and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - counter advances only while the enable bit is set
// - idle-halt bit set stops the timer while device idles
// - lockout set drops counter writes while a transfer is pending
// - lockout clear accepts back-to-back counter writes
// - pending flag reads one during asynchronous counter write transfer
// - pending flag reads zero in synchronous mode
// - gating applies only with internal clock selected
// - prescale codes 0..3 divide by 1, 8, 64, 256
// - unimplemented control bits read zero and ignore writes
module tatc_timer (
  // clock and reset
  input  wire logic                          sys_clk,
  input  wire logic                          rst_n,
  // axi4-lite write address and data
  input  wire logic [tatc_pkg::ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  input  wire logic [31:0]                   s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  // axi4-lite write response
  output logic [1:0]                         s_axi_bresp,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  // axi4-lite read
  input  wire logic [tatc_pkg::ADDR_W-1:0]   s_axi_araddr,
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  output logic [31:0]                        s_axi_rdata,
  output logic [1:0]                         s_axi_rresp,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  // device and timer pins
  input  wire logic                          idleMode,
  input  wire logic                          extClkTick,
  input  wire logic                          gateIn,
  output logic                               periodMatch
);
  import tatc_pkg::*;

  logic [31:0]      ctrl_q, ctrl_d;
  logic [15:0]      count_q, count_d, period_q, period_d;
  logic [PS_W-1:0]  ps_q, ps_d;
  logic [15:0]      wval_q, wval_d;
  logic [1:0]       wcnt_q, wcnt_d;
  tatc_wst_t        wst_q, wst_d;
  logic             awHeld_q, awHeld_d, wHeld_q, wHeld_d;
  logic [ADDR_W-1:0] awa_q, awa_d;
  logic [31:0]      wdat_q, wdat_d;
  logic [3:0]       wstb_q, wstb_d;
  logic             bval_q, bval_d, rval_q, rval_d;
  logic [1:0]       bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0]      rdat_q, rdat_d;
  logic             match_q, match_d;
  logic             extPrev_q;
  logic             asyncMode, run, srcTick, gated, psTick, wrFire, cntWr, wrDrop;

  function automatic logic [PS_W-1:0] psLimit(input logic [1:0] code);
    unique case (code)
      2'b00: psLimit = PS_MAX1;
      2'b01: psLimit = PS_MAX8;
      2'b10: psLimit = PS_MAX64;
      2'b11: psLimit = PS_MAX256;
    endcase
  endfunction

  function automatic logic [31:0] mergeStrb(input logic [31:0] old, input logic [31:0] nw,
                                           input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    mergeStrb = r;
  endfunction

  // bus handshakes: address and data taken independently
  assign s_axi_awready = !awHeld_q && !bval_q;
  assign s_axi_wready  = !wHeld_q && !bval_q;
  assign s_axi_arready = !rval_q;
  assign s_axi_bvalid  = bval_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_rvalid  = rval_q;
  assign s_axi_rresp   = rresp_q;
  assign s_axi_rdata   = rdat_q;
  assign periodMatch   = match_q;
  assign wrFire = (awHeld_q || (s_axi_awvalid && s_axi_awready)) &&
                  (wHeld_q || (s_axi_wvalid && s_axi_wready)) && !bval_q;

  // source select and sync mode
  // source and sync selection
  assign asyncMode = ctrl_q[CS_BIT] && !ctrl_q[SYNC_BIT];
  assign srcTick = ctrl_q[CS_BIT] ? (extClkTick && !extPrev_q) : 1'b1;
  assign gated = ctrl_q[GATE_BIT] && !ctrl_q[CS_BIT] && !gateIn;
  assign run = ctrl_q[ON_BIT] && !(ctrl_q[IDLE_BIT] && idleMode);
  assign psTick = run && srcTick && !gated && (ps_q >= psLimit(ctrl_q[PS_LO +: 2]));

  always_comb begin
    awHeld_d = awHeld_q;
    wHeld_d  = wHeld_q;
    awa_d    = awa_q;
    wdat_d   = wdat_q;
    wstb_d   = wstb_q;
    bval_d   = bval_q;
    bresp_d  = bresp_q;
    rval_d   = rval_q;
    rresp_d  = rresp_q;
    rdat_d   = rdat_q;
    ctrl_d   = ctrl_q;
    period_d = period_q;
    cntWr    = 1'b0;
    wrDrop   = 1'b0;
    if (s_axi_awvalid && s_axi_awready) begin
      awHeld_d = 1'b1;
      awa_d    = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      wHeld_d = 1'b1;
      wdat_d  = s_axi_wdata;
      wstb_d  = s_axi_wstrb;
    end
    if (wrFire) begin
      awHeld_d = 1'b0;
      wHeld_d  = 1'b0;
      bval_d   = 1'b1;
      bresp_d  = RESP_OK;
      unique case (awa_d)
        CTRL_OFS:   ctrl_d = mergeStrb(ctrl_q, wdat_d, wstb_d) & CTRL_WMASK;
        PERIOD_OFS: period_d = 16'(mergeStrb({16'h0000, period_q}, wdat_d, wstb_d));
        // lockout decides whether a pending write blocks
        COUNT_OFS: begin
          if (ctrl_q[LOCK_BIT] && wst_q != TATC_IDLE) begin
            wrDrop = 1'b1;
          end else begin
            cntWr = 1'b1;
          end
        end
        STAT_OFS: bresp_d = RESP_OK;
        default:  bresp_d = RESP_ERR;
      endcase
    end else if (bval_q && s_axi_bready) begin
      bval_d = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rval_d  = 1'b1;
      rresp_d = RESP_OK;
      unique case (s_axi_araddr)
        // pending flag only in asynchronous mode
        CTRL_OFS:   rdat_d = (ctrl_q & CTRL_WMASK) |
                             (32'(asyncMode && wst_q != TATC_IDLE) << PEND_BIT);
        COUNT_OFS:  rdat_d = {16'h0000, count_q};
        PERIOD_OFS: rdat_d = {16'h0000, period_q};
        STAT_OFS:   rdat_d = {30'h0, run, asyncMode};
        default: begin
          rdat_d  = 32'h0000_0000;
          rresp_d = RESP_ERR;
        end
      endcase
    end else if (rval_q && s_axi_rready) begin
      rval_d = 1'b0;
    end
  end

  // counter write transfer: synchronous mode lands at once
  always_comb begin
    wst_d   = wst_q;
    wcnt_d  = wcnt_q;
    wval_d  = wval_q;
    count_d = count_q;
    ps_d    = ps_q;
    match_d = 1'b0;
    if (run && srcTick && !gated) begin
      ps_d = psTick ? '0 : PS_W'(ps_q + 1'b1);
    end
    if (!ctrl_q[ON_BIT]) begin
      ps_d = '0;
    end
    if (psTick) begin
      if (count_q == period_q) begin
        count_d = 16'h0000;
        match_d = 1'b1;
      end else begin
        count_d = 16'(count_q + 1'b1);
      end
    end
    unique case (wst_q)
      TATC_IDLE: ;
      TATC_XFER: begin
        if (srcTick) begin
          wcnt_d = 2'(wcnt_q + 1'b1);
        end
        if (wcnt_q == XFER_STEPS) begin
          wst_d = TATC_DONE;
        end
      end
      TATC_DONE: begin
        count_d = wval_q;
        wst_d   = TATC_IDLE;
      end
    endcase
    if (cntWr) begin
      wval_d = wdat_d[15:0];
      wcnt_d = 2'h0;
      if (asyncMode) begin
        wst_d = TATC_XFER;
      end else begin
        count_d = wdat_d[15:0];
        wst_d   = TATC_IDLE;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q    <= CTRL_RST;
      period_q  <= PERIOD_RST;
      count_q   <= 16'h0000;
      ps_q      <= '0;
      wval_q    <= 16'h0000;
      wcnt_q    <= 2'h0;
      wst_q     <= TATC_IDLE;
      awHeld_q  <= 1'b0;
      wHeld_q   <= 1'b0;
      awa_q     <= '0;
      wdat_q    <= 32'h0000_0000;
      wstb_q    <= 4'h0;
      bval_q    <= 1'b0;
      bresp_q   <= 2'h0;
      rval_q    <= 1'b0;
      rresp_q   <= 2'h0;
      rdat_q    <= 32'h0000_0000;
      match_q   <= 1'b0;
      extPrev_q <= 1'b0;
    end else begin
      ctrl_q    <= ctrl_d;
      period_q  <= period_d;
      count_q   <= count_d;
      ps_q      <= ps_d;
      wval_q    <= wval_d;
      wcnt_q    <= wcnt_d;
      wst_q     <= wst_d;
      awHeld_q  <= awHeld_d;
      wHeld_q   <= wHeld_d;
      awa_q     <= awa_d;
      wdat_q    <= wdat_d;
      wstb_q    <= wstb_d;
      bval_q    <= bval_d;
      bresp_q   <= bresp_d;
      rval_q    <= rval_d;
      rresp_q   <= rresp_d;
      rdat_q    <= rdat_d;
      match_q   <= match_d;
      extPrev_q <= extClkTick;
    end
  end

  stopped_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !ctrl_q[ON_BIT] && wst_q == TATC_IDLE && !cntWr |=> $stable(count_q))
    else $error("counter moved while disabled");
  idle_halt_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ctrl_q[IDLE_BIT] && idleMode && wst_q == TATC_IDLE && !cntWr |=> $stable(count_q))
    else $error("timer ran in idle");
  lock_drop_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wrDrop |=> $stable(wval_q))
    else $error("locked write accepted");
  back_to_back_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wrFire && awa_d == COUNT_OFS && !ctrl_q[LOCK_BIT] |-> cntWr)
    else $error("unlocked write lost");
  // async write is pending on the cycle after it is accepted
  async_pend_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    cntWr && asyncMode |=> wst_q == TATC_XFER)
    else $error("async write not pending");
  sync_land_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    cntWr && !asyncMode |=> wst_q == TATC_IDLE && count_q == $past(wdat_d[15:0]))
    else $error("sync write not direct");
  gate_ignore_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ctrl_q[CS_BIT] && run && srcTick && ctrl_q[PS_LO +: 2] == 2'b00 |-> psTick)
    else $error("gate active on external clock");
  reserved_zero_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (ctrl_q & ~CTRL_WMASK) == 32'h0000_0000)
    else $error("unimplemented bit set");
  div_eight_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    psTick && !ctrl_q[CS_BIT] && !ctrl_q[GATE_BIT] && ctrl_q[PS_LO +: 2] == 2'b01 && !ctrl_d[CS_BIT]
    |=> (!psTick || ctrl_q[PS_LO +: 2] == 2'b00) [*7])
    else $error("prescale spacing wrong");

  run_c: cover property (@(posedge sys_clk) disable iff (!rst_n) psTick);
  match_c: cover property (@(posedge sys_clk) disable iff (!rst_n) match_q);
  drop_c: cover property (@(posedge sys_clk) disable iff (!rst_n) wrDrop);
  async_c: cover property (@(posedge sys_clk) disable iff (!rst_n) wst_q == TATC_DONE);
endmodule
`default_nettype wire

// ### core/tatc_pkg.sv
// constants and types for the timer control block
package tatc_pkg;
  localparam int unsigned ADDR_W = 4;
  localparam logic [ADDR_W-1:0] CTRL_OFS  = 4'h0;
  localparam logic [ADDR_W-1:0] COUNT_OFS = 4'h4;
  localparam logic [ADDR_W-1:0] PERIOD_OFS = 4'h8;
  localparam logic [ADDR_W-1:0] STAT_OFS  = 4'hC;
  localparam int unsigned ON_BIT = 15;
  localparam int unsigned IDLE_BIT = 13;
  localparam int unsigned LOCK_BIT = 12;
  localparam int unsigned PEND_BIT = 11;
  localparam int unsigned GATE_BIT = 7;
  localparam int unsigned PS_LO = 4;
  localparam int unsigned SYNC_BIT = 2;
  localparam int unsigned CS_BIT = 1;
  localparam logic [31:0] CTRL_WMASK = 32'h0000_B0B6;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [15:0] PERIOD_RST = 16'hFFFF;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  localparam int unsigned PS_W = 8;
  localparam logic [PS_W-1:0] PS_MAX1 = 8'h00;
  localparam logic [PS_W-1:0] PS_MAX8 = 8'h07;
  localparam logic [PS_W-1:0] PS_MAX64 = 8'h3F;
  localparam logic [PS_W-1:0] PS_MAX256 = 8'hFF;
  localparam logic [1:0] XFER_STEPS = 2'h2;
  typedef enum logic [1:0] {
    TATC_IDLE = 2'b00,
    TATC_XFER = 2'b01,
    TATC_DONE = 2'b11
  } tatc_wst_t;
endpackage

// ### tb/tb_top.sv
// self-checking bench for the timer control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import tatc_pkg::*;
  logic                    sys_clk = 1'b0;
  logic                    rst_n = 1'b0;
  logic [ADDR_W-1:0]       awAddr = '0;
  logic [ADDR_W-1:0]       arAddr = '0;
  logic [31:0]             wData = '0;
  logic [3:0]              wStrb = '0;
  logic                    awValid = 1'b0, wValid = 1'b0, bReady = 1'b1, arValid = 1'b0, rReady = 1'b1;
  logic                    idleMode = 1'b0, extClkTick = 1'b0, gateIn = 1'b0, tickEn = 1'b0;
  wire logic               awReady, wReady, bValid, arReady, rValid, periodMatch;
  wire logic [1:0]         bResp, rResp;
  wire logic [31:0]        rData;
  int                      nFail = 0, nChecks = 0, cycles = 0, seed = 84, n;
  logic [31:0]             rd, ctrlExp, d, b;
  logic [3:0]              s;
  logic [1:0]              rsp;
  logic [15:0]             c1;

  tatc_timer u_tatc_timer (.sys_clk(sys_clk), .rst_n(rst_n),
    .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
    .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
    .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
    .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
    .idleMode(idleMode), .extClkTick(extClkTick), .gateIn(gateIn), .periodMatch(periodMatch));

  always #12.5 sys_clk = ~sys_clk;

  // external tick source and run limit
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (tickEn) extClkTick <= ~extClkTick;
    if (cycles == 30000) begin
      nFail++;
      completeRun();
    end
  end

  task completeRun;
    if (nFail == 0 && nChecks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task chk(input logic ok, input string m);
    nChecks++;
    if (ok !== 1'b1) begin
      nFail++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask

  task wr(input logic [3:0] a, input logic [31:0] v, input logic [3:0] st);
    awAddr <= a; wData <= v; wStrb <= st;
    awValid <= 1'b1; wValid <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (awReady) awValid <= 1'b0;
      if (wReady) wValid <= 1'b0;
    end while (bValid !== 1'b1);
    rsp = bResp;
  endtask

  task rdr(input logic [3:0] a);
    arAddr <= a; arValid <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (arReady) arValid <= 1'b0;
    end while (rValid !== 1'b1);
    rd = rData;
    rsp = rResp;
  endtask

  function automatic logic [31:0] merge(input logic [31:0] old, v, input logic [3:0] st);
    logic [31:0] m;
    m = {{8{st[3]}}, {8{st[2]}}, {8{st[1]}}, {8{st[0]}}};
    return ((old & ~m) | (v & m)) & CTRL_WMASK;
  endfunction

  function automatic int divOf(input logic [1:0] c);
    return (c == 2'd0) ? 1 : (c == 2'd1) ? 8 : (c == 2'd2) ? 64 : 256;
  endfunction

  // counts edges up to the next period pulse
  task waitPulse;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (periodMatch !== 1'b1 && n < 3000);
  endtask

  // writes control, then reports whether the counter moved over 24 cycles
  task runs(input logic [31:0] ctl, input logic move, input string m);
    wr(CTRL_OFS, ctl, 4'hF);
    @(posedge sys_clk);
    rdr(COUNT_OFS);
    c1 = rd[15:0];
    repeat (24) @(posedge sys_clk);
    rdr(COUNT_OFS);
    chk((rd[15:0] !== c1) === move, m);
  endtask

  initial begin
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    rdr(CTRL_OFS);
    chk(rd === CTRL_RST, "control reset value");
    ctrlExp = CTRL_RST;
    repeat (12) begin
      d = $random(seed);
      s = $random(seed);
      ctrlExp = merge(ctrlExp, d, s);
      wr(CTRL_OFS, d, s);
      chk(rsp === RESP_OK, "control write response");
      rdr(CTRL_OFS);
      chk(rd === ctrlExp, "control readback");
    end
    rdr(4'h2);
    chk(rsp === RESP_ERR && rd === 32'h0000_0000, "unmapped read");
    wr(CTRL_OFS, 32'h0000_0000, 4'hF);
    wr(COUNT_OFS, 32'h0000_0000, 4'hF);
    wr(PERIOD_OFS, 32'h0000_0002, 4'hF);
    for (int c = 0; c < 4; c++) begin
      wr(CTRL_OFS, (32'h1 << ON_BIT) | (32'(c) << PS_LO), 4'hF);
      waitPulse();
      waitPulse();
      waitPulse();
      chk(n == 3 * divOf(2'(c)), "prescaled period interval");
    end
    wr(PERIOD_OFS, 32'h0000_FFFF, 4'hF);
    runs(32'h1 << ON_BIT, 1'b1, "enabled counter still");
    runs(32'h0, 1'b0, "disabled counter moved");
    idleMode <= 1'b1;
    runs((32'h1 << ON_BIT) | (32'h1 << IDLE_BIT), 1'b0, "idle halt ignored");
    runs(32'h1 << ON_BIT, 1'b1, "idle stopped timer");
    idleMode <= 1'b0;
    runs((32'h1 << ON_BIT) | (32'h1 << GATE_BIT), 1'b0, "gate low still counting");
    gateIn <= 1'b1;
    runs((32'h1 << ON_BIT) | (32'h1 << GATE_BIT), 1'b1, "gate high not counting");
    gateIn <= 1'b0;
    tickEn <= 1'b1;
    runs((32'h1 << ON_BIT) | (32'h1 << GATE_BIT) | (32'h1 << CS_BIT) | (32'h1 << SYNC_BIT), 1'b1,
         "gate not ignored on external source");
    tickEn <= 1'b0;
    wr(COUNT_OFS, $random(seed), 4'hF);
    rdr(CTRL_OFS);
    chk(rd[PEND_BIT] === 1'b0, "pending set in sync mode");
    for (int lk = 1; lk >= 0; lk--) begin
      wr(CTRL_OFS, (32'(lk) << LOCK_BIT) | (32'h1 << CS_BIT), 4'hF);
      d = $random(seed);
      b = $random(seed);
      wr(COUNT_OFS, d, 4'hF);
      rdr(CTRL_OFS);
      chk(rd[PEND_BIT] === 1'b1, "pending not set");
      wr(COUNT_OFS, b, 4'hF);
      tickEn <= 1'b1;
      repeat (40) @(posedge sys_clk);
      tickEn <= 1'b0;
      rdr(CTRL_OFS);
      chk(rd[PEND_BIT] === 1'b0, "pending not cleared");
      rdr(COUNT_OFS);
      chk(rd[15:0] === (lk ? d[15:0] : b[15:0]), "async counter write");
    end
    wr(CTRL_OFS, (32'h1 << ON_BIT) | (32'h1 << CS_BIT), 4'hF);
    rdr(STAT_OFS);
    chk(rd[1:0] === 2'b11, "status running async");
    completeRun();
  end
endmodule
`default_nettype wire
